// File: verilog/cgm_mode_ctrl.sv
// Purpose: mode sequencing, filter, trim and stop control of the
//          clock generator
// Assumes: loop lock, reference and loss flags come from same-clock logic;
//          xtalClkMon and oscClkMon are asynchronous
// Notes:   analog frequency effects are controlled codes, not modelled
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "cgm_regs.svh"

// Operation
// - stable flag sets after two in-range samples with a toggling oscillator
// - stable flag clears when entering off
// - leaving off with loop mode selected waits for stable flag
// - self-clocked mode monitors oscillator loss only once stable
// - filter readable always, writable only with mode select 00
// - filter is 12 bits; upper write loads the whole value
// - upper write ignored while an earlier latch is still running
// - larger trim lengthens reference period, smaller shortens it
// - stop without exceptions halts all clocks, off state
// - debug enabled keeps all clocks running through stop
// - oscillator keep runs generators but gates the chip clock feed
// - interrupt exit from stop keeps control bits, resumes feed
// - interrupt exit from off in external loop mode runs self-clocked first
// - interrupt exit from off in bypass mode holds output off until reference stable
// - reset restores defaults except trim, self-clocked at default filter
// - crystal needs 4096 crystal clocks before external reference is used
// - self-clocked after reset, off exit not 10, or select X1 to 00
// - external mode falls back to self-clocked when reference lost
// - self-clocked keeps loop open, oscillator on, output divided
// - self-clocked filter writes set the oscillator frequency
// - self-clocked entry keeps frequency; doubles from unlocked ext loop
// - off exit with 01 or 11 waits stable then closes the loop
// - mode codes 00 self, 01 internal loop, 10 bypass, 11 external loop
// - divider code 000 divides by 1, each step doubles
module cgm_mode_ctrl (
  // clock and resets
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               porResetn,
  // register port
  input  wire logic [2:0]         regAddr,
  input  wire logic [7:0]         regWrData,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [7:0]         regRdData,
  // cpu stop handshake
  input  wire cgm_pkg::cgm_stop_t stopIn,
  // loop and reference status
  input  wire logic               sampleValid,
  input  wire logic signed [7:0]  countErr,
  input  wire logic               loopLocked,
  input  wire logic               extRefOkFlag,
  input  wire logic               clockLossFlag,
  // asynchronous clock monitors
  input  wire logic               oscClkMon,
  input  wire logic               xtalClkMon,
  // oscillator and clock path controls
  output logic      [11:0]        loopFilterValue,
  output logic      [7:0]         trimCode,
  output logic                    oscRun,
  output logic                    extRefRun,
  output logic                    loopClosed,
  output logic                    useExtRef,
  output logic                    chipClkEn,
  output logic                    outClkEn,
  output logic      [3:0]         outDivShift,
  output logic                    oscMonEn,
  output logic                    oscStableFlag,
  output logic      [1:0]         modeState
);

  cgm_pkg::cgm_ctrl_t  ctrl_q;
  cgm_pkg::cgm_state_t state_q;
  cgm_pkg::cgm_state_t state_d;
  cgm_pkg::cgm_state_t saved_q;
  logic [7:0]          lowerStage_q;
  logic [1:0]          latchCnt_q;
  logic                feeLockedOnce_q;
  logic                xS1_q;
  logic                xS2_q;
  logic                xS3_q;
  logic [12:0]         xtalCnt_q;
  logic                xtalDone;
  logic                extUsable;
  logic                extLost;
  logic                inStop;
  logic                offEnter;
  logic                wrCtrl;
  logic [7:0]          rdMux;

  // state to reported mode code
  function automatic logic [1:0] modeCode(cgm_pkg::cgm_state_t s);
    logic [1:0] c;
    c = 2'h0;
    unique case (s)
      cgm_pkg::ST_FEI:   c = 2'h1;
      cgm_pkg::ST_FBE:   c = 2'h2;
      cgm_pkg::ST_WAITX: c = 2'h2;
      cgm_pkg::ST_FEE:   c = 2'h3;
      cgm_pkg::ST_OFF,
      cgm_pkg::ST_HOLD,
      cgm_pkg::ST_SCM:   c = 2'h0;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // stability detector
  // ----------------------------------------------------------------------
  cgm_stable_det uStable (
    .clk         (clk),
    .resetn      (resetn),
    .sampleValid (sampleValid),
    .countErr    (countErr),
    .oscClkMon   (oscClkMon),
    .offEnter    (offEnter),
    .stable      (oscStableFlag)
  );

  // ----------------------------------------------------------------------
  // crystal start-up count
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xS1_q <= 1'b0;
      xS2_q <= 1'b0;
      xS3_q <= 1'b0;
    end else begin
      xS1_q <= xtalClkMon;
      xS2_q <= xS1_q;
      xS3_q <= xS2_q;
    end
  end

  // crystal edges are counted at system clock rate, so the crystal
  // must run below half of clk for the count to be exact
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xtalCnt_q <= 13'h0000;
    end else if (offEnter || !ctrl_q.crystalSel) begin
      xtalCnt_q <= 13'h0000;
    end else if (!xtalDone && xS2_q && !xS3_q) begin
      xtalCnt_q <= xtalCnt_q + 13'h0001;
    end
  end

  assign xtalDone  = (xtalCnt_q == `CGM_XTAL_COUNT);
  assign extUsable = extRefOkFlag && (!ctrl_q.crystalSel || xtalDone);
  assign extLost   = !extRefOkFlag && clockLossFlag;
  assign inStop    = stopIn.stopReq && !stopIn.debugEn;
  assign offEnter  = (state_d == cgm_pkg::ST_OFF) &&
                     (state_q != cgm_pkg::ST_OFF);
  assign wrCtrl    = regWr && (regAddr == `CGM_OFS_CTRL);

  // ----------------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cgm_pkg::ST_OFF: begin
        if (stopIn.wakeIrq) begin
          if (ctrl_q.modeSelect == cgm_pkg::SEL_BYP_EXT) begin
            state_d = extUsable ? cgm_pkg::ST_FBE : cgm_pkg::ST_WAITX;
          end else begin
            state_d = cgm_pkg::ST_SCM;
          end
        end
      end
      cgm_pkg::ST_HOLD: begin
        if (stopIn.wakeIrq) begin
          state_d = saved_q;
        end
      end
      cgm_pkg::ST_WAITX: begin
        if (extLost || ctrl_q.modeSelect != cgm_pkg::SEL_BYP_EXT) begin
          state_d = cgm_pkg::ST_SCM;
        end else if (extUsable) begin
          state_d = cgm_pkg::ST_FBE;
        end
      end
      cgm_pkg::ST_SCM, cgm_pkg::ST_FEI, cgm_pkg::ST_FBE,
      cgm_pkg::ST_FEE: begin
        unique case (ctrl_q.modeSelect)
          cgm_pkg::SEL_SELF: state_d = cgm_pkg::ST_SCM;
          cgm_pkg::SEL_LOOP_INT: begin
            state_d = oscStableFlag ? cgm_pkg::ST_FEI : cgm_pkg::ST_SCM;
          end
          cgm_pkg::SEL_BYP_EXT: begin
            if (extLost) begin
              state_d = cgm_pkg::ST_SCM;
            end else if (extUsable) begin
              state_d = cgm_pkg::ST_FBE;
            end else if (state_q != cgm_pkg::ST_FBE) begin
              state_d = cgm_pkg::ST_SCM;
            end
          end
          cgm_pkg::SEL_LOOP_EXT: begin
            if (extLost) begin
              state_d = cgm_pkg::ST_SCM;
            end else if (state_q == cgm_pkg::ST_FEE && clockLossFlag) begin
              state_d = cgm_pkg::ST_FBE;
            end else if (oscStableFlag && extUsable) begin
              state_d = cgm_pkg::ST_FEE;
            end else if (state_q != cgm_pkg::ST_FEE) begin
              state_d = cgm_pkg::ST_SCM;
            end
          end
        endcase
      end
    endcase
    // stop overrides everything except the stop states themselves
    if (inStop && state_q != cgm_pkg::ST_OFF &&
        state_q != cgm_pkg::ST_HOLD) begin
      state_d = ctrl_q.oscKeep ? cgm_pkg::ST_HOLD : cgm_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= cgm_pkg::ST_SCM;
    end else begin
      state_q <= state_d;
    end
  end

  // state to return to when a held stop ends
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      saved_q <= cgm_pkg::ST_SCM;
    end else if (state_d == cgm_pkg::ST_HOLD &&
                 state_q != cgm_pkg::ST_HOLD) begin
      saved_q <= state_q;
    end
  end

  // tracks whether the external loop has locked since it was entered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      feeLockedOnce_q <= 1'b0;
    end else if (state_q != cgm_pkg::ST_FEE) begin
      feeLockedOnce_q <= 1'b0;
    end else if (loopLocked) begin
      feeLockedOnce_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  // resetn clears control bits; stop alone never does
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `CGM_CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_q.modeSelect <= cgm_pkg::cgm_mode_t'(
        regWrData[`CGM_MODESEL_LSB +: 2]);
      ctrl_q.divCode    <= regWrData[`CGM_DIV_LSB +: 3];
      ctrl_q.oscKeep    <= regWrData[`CGM_OSCKEEP_BIT];
      ctrl_q.crystalSel <= regWrData[`CGM_XTAL_BIT];
    end else if (state_q == cgm_pkg::ST_SCM && state_d == cgm_pkg::ST_SCM
                 && ctrl_q.modeSelect[1] && extLost) begin
      // fallback is reflected in the select field
      ctrl_q.modeSelect <= cgm_pkg::SEL_SELF;
    end
  end

  // ----------------------------------------------------------------------
  // loop filter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowerStage_q <= 8'(`CGM_FILT_RESET);
    end else if (regWr && regAddr == `CGM_OFS_FILT_LOWER &&
                 ctrl_q.modeSelect == cgm_pkg::SEL_SELF) begin
      lowerStage_q <= regWrData;
    end
  end

  // the latch window keeps a second upper write from tearing the value
  // while the oscillator is still settling onto the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loopFilterValue <= `CGM_FILT_RESET;
      latchCnt_q      <= 2'h0;
    end else begin
      if (latchCnt_q != 2'h0) begin
        latchCnt_q <= latchCnt_q - 2'h1;
      end
      if (regWr && regAddr == `CGM_OFS_FILT_UPPER &&
          ctrl_q.modeSelect == cgm_pkg::SEL_SELF &&
          latchCnt_q == 2'h0) begin
        loopFilterValue <= {regWrData[3:0], lowerStage_q};
        latchCnt_q      <= `CGM_LATCH_CYCLES;
      end
    end
  end

  // ----------------------------------------------------------------------
  // trim, kept across every reset but power-on
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge porResetn) begin
    if (!porResetn) begin
      trimCode <= `CGM_TRIM_RESET;
    end else if (regWr && regAddr == `CGM_OFS_TRIM) begin
      trimCode <= regWrData;
    end
  end

  // ----------------------------------------------------------------------
  // clock path controls
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscRun      <= 1'b1;
      extRefRun   <= 1'b0;
      loopClosed  <= 1'b0;
      useExtRef   <= 1'b0;
      chipClkEn   <= 1'b1;
      outClkEn    <= 1'b1;
      outDivShift <= 4'h0;
      oscMonEn    <= 1'b0;
      modeState   <= 2'h0;
    end else begin
      oscRun     <= state_d != cgm_pkg::ST_OFF &&
                    state_d != cgm_pkg::ST_FBE &&
                    state_d != cgm_pkg::ST_WAITX;
      extRefRun  <= (state_d != cgm_pkg::ST_OFF) &&
                    (ctrl_q.modeSelect[1] || state_d == cgm_pkg::ST_HOLD);
      loopClosed <= state_d == cgm_pkg::ST_FEI ||
                    state_d == cgm_pkg::ST_FEE;
      useExtRef  <= state_d == cgm_pkg::ST_FBE ||
                    state_d == cgm_pkg::ST_FEE;
      chipClkEn  <= state_d != cgm_pkg::ST_OFF &&
                    state_d != cgm_pkg::ST_HOLD;
      outClkEn   <= state_d != cgm_pkg::ST_OFF &&
                    state_d != cgm_pkg::ST_HOLD &&
                    state_d != cgm_pkg::ST_WAITX;
      outDivShift <= {1'b0, ctrl_q.divCode} +
                     {3'h0, (state_d == cgm_pkg::ST_FEE &&
                             !feeLockedOnce_q)};
      oscMonEn   <= (state_d == cgm_pkg::ST_SCM) ? oscStableFlag :
                    (state_d == cgm_pkg::ST_FEI ||
                     state_d == cgm_pkg::ST_FEE);
      modeState  <= (state_d == cgm_pkg::ST_OFF ||
                     state_d == cgm_pkg::ST_HOLD) ? modeCode(saved_q)
                                                  : modeCode(state_d);
    end
  end

  // ----------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------
  always_comb begin
    rdMux = 8'h00;
    unique case (regAddr)
      `CGM_OFS_CTRL:        rdMux = {1'b0, ctrl_q};
      `CGM_OFS_MODE_STATUS: begin
        rdMux[`CGM_MODESTATE_LSB +: 2] = modeState;
        rdMux[`CGM_LOSS_BIT]           = clockLossFlag;
        rdMux[`CGM_EXTOK_BIT]          = extRefOkFlag;
      end
      `CGM_OFS_OSC_STABLE:  rdMux[`CGM_STABLE_BIT] = oscStableFlag;
      `CGM_OFS_FILT_UPPER:  rdMux = {4'h0, loopFilterValue[11:8]};
      `CGM_OFS_FILT_LOWER:  rdMux = loopFilterValue[7:0];
      `CGM_OFS_TRIM:        rdMux = trimCode;
      default:              rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // cgm_mode_ctrl

// File: pkg/cgm_regs.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 8-bit register port, 3-bit byte address
// Notes:   definitions only
`ifndef CGM_REGS_SVH
`define CGM_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CGM_OFS_CTRL          3'h0
`define CGM_OFS_MODE_STATUS   3'h1
`define CGM_OFS_OSC_STABLE    3'h2
`define CGM_OFS_FILT_UPPER    3'h3
`define CGM_OFS_FILT_LOWER    3'h4
`define CGM_OFS_TRIM          3'h5

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CGM_MODESEL_LSB       0
`define CGM_DIV_LSB           2
`define CGM_OSCKEEP_BIT       5
`define CGM_XTAL_BIT          6
`define CGM_MODESTATE_LSB     6
`define CGM_LOSS_BIT          2
`define CGM_EXTOK_BIT         1
`define CGM_STABLE_BIT        0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CGM_CTRL_RESET        7'h00
`define CGM_FILT_RESET        12'h200
`define CGM_TRIM_RESET        8'h80

// ----------------------------------------------------------------------
// counts and thresholds
// ----------------------------------------------------------------------
`define CGM_XTAL_COUNT        13'h1000
`define CGM_LATCH_CYCLES      2'h2
`define CGM_STATIC_LIMIT      5'h10
`define CGM_UNLOCK_THRESH     8'h08

`endif

// File: pkg/cgm_pkg.sv
// Purpose: shared types of the clock generator mode control
// Assumes: constants live in cgm_regs.svh
// Notes:   no imports; users write cgm_pkg::name
package cgm_pkg;

  // mode select / mode state codes
  typedef enum logic [1:0] {
    SEL_SELF     = 2'h0,
    SEL_LOOP_INT = 2'h1,
    SEL_BYP_EXT  = 2'h2,
    SEL_LOOP_EXT = 2'h3
  } cgm_mode_t;

  // software control register
  typedef struct packed {
    logic      crystalSel;
    logic      oscKeep;
    logic [2:0] divCode;
    cgm_mode_t modeSelect;
  } cgm_ctrl_t;

  // stop handshake from the cpu side
  typedef struct packed {
    logic stopReq;
    logic debugEn;
    logic wakeIrq;
  } cgm_stop_t;

  // internal operating states
  typedef enum logic [2:0] {
    ST_OFF, ST_HOLD, ST_SCM, ST_FEI, ST_FBE, ST_FEE, ST_WAITX
  } cgm_state_t;

endpackage

// File: verilog/cgm_stable_det.sv
// Purpose: oscillator-stable flag from count error samples and activity
// Assumes: oscClkMon comes from the oscillator domain
// Notes:   flag drops at once when the generator enters off
`timescale 1ns/1ps
`include "cgm_regs.svh"

module cgm_stable_det (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // loop samples
  input  wire logic              sampleValid,
  input  wire logic signed [7:0] countErr,
  input  wire logic              oscClkMon,
  // control
  input  wire logic              offEnter,
  // result
  output logic                   stable
);

  logic       monS1_q;
  logic       monS2_q;
  logic       monS3_q;
  logic [4:0] idleCnt_q;
  logic       inRangeLast_q;
  logic       inRange;
  logic       toggling;

  // ----------------------------------------------------------------------
  // activity monitor
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monS1_q <= 1'b0;
      monS2_q <= 1'b0;
      monS3_q <= 1'b0;
    end else begin
      monS1_q <= oscClkMon;
      monS2_q <= monS1_q;
      monS3_q <= monS2_q;
    end
  end

  // a stuck clock saturates the idle count and reads as static
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idleCnt_q <= `CGM_STATIC_LIMIT;
    end else if (monS2_q != monS3_q) begin
      idleCnt_q <= 5'h00;
    end else if (idleCnt_q != `CGM_STATIC_LIMIT) begin
      idleCnt_q <= idleCnt_q + 5'h01;
    end
  end

  assign toggling = (idleCnt_q != `CGM_STATIC_LIMIT);
  assign inRange  = (countErr <= $signed(`CGM_UNLOCK_THRESH)) &&
                    (countErr >= -$signed(`CGM_UNLOCK_THRESH));

  // ----------------------------------------------------------------------
  // two consecutive good samples
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inRangeLast_q <= 1'b0;
      stable        <= 1'b0;
    end else if (offEnter) begin
      inRangeLast_q <= 1'b0;
      stable        <= 1'b0;
    end else begin
      if (sampleValid) begin
        inRangeLast_q <= inRange;
        if (inRange && inRangeLast_q && toggling) begin
          stable <= 1'b1;
        end
      end
      if (!toggling) begin
        stable <= 1'b0;
      end
    end
  end

endmodule // cgm_stable_det

// File: bench/cgm_mode_checker.sv
// Purpose: port assertions for the mode control
// Assumes: one clock, reset active low
// Notes:   bound to cgm_mode_ctrl
`timescale 1ns/1ps
module cgm_mode_checker (
  // clock and reset
  input wire logic               clk,
  input wire logic               resetn,
  // watched ports
  input wire logic [2:0]         regAddr,
  input wire logic               regWr,
  input wire logic               regRd,
  input wire logic [7:0]         regRdData,
  input wire cgm_pkg::cgm_stop_t stopIn,
  input wire logic [11:0]        loopFilterValue,
  input wire logic               oscRun,
  input wire logic               loopClosed,
  input wire logic               useExtRef,
  input wire logic               chipClkEn,
  input wire logic               outClkEn,
  input wire logic               oscMonEn,
  input wire logic               oscStableFlag,
  input wire logic [1:0]         modeState
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence stopNoDebug;
    stopIn.stopReq && !stopIn.debugEn && !stopIn.wakeIrq;
  endsequence
  sequence stopDebug;
    stopIn.stopReq && stopIn.debugEn && chipClkEn;
  endsequence
  a_rd_idle_zero:
    assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not zero outside read slot");
  a_filt_only_upper:
    assert property (modeState == 2'h0 && $past(modeState) == 2'h0
      && !$past(regWr) |-> $stable(loopFilterValue))
    else $error("filter changed without a write");
  a_latch_window:
    assert property ($changed(loopFilterValue) && modeState == 2'h0
      |=> $stable(loopFilterValue) [*2])
    else $error("filter reloaded inside latch window");
  a_stable_off:
    assert property (!oscRun && !chipClkEn |-> ##[0:1] !oscStableFlag)
    else $error("stable flag set in off state");
  a_mon_after_stable:
    assert property ($rose(oscMonEn) && modeState == 2'h0
      |-> oscStableFlag || $past(oscStableFlag))
    else $error("loss monitor enabled before stable");
  a_stop_halts:
    assert property (stopNoDebug |-> ##[1:3] !chipClkEn)
    else $error("chip clock still fed in stop");
  a_debug_runs:
    assert property (stopDebug |=> chipClkEn)
    else $error("chip clock dropped with debug on");
  a_mode_paths:
    assert property (chipClkEn && outClkEn |-> loopClosed == modeState[0]
      && useExtRef == modeState[1])
    else $error("clock path does not match mode");
endmodule // cgm_mode_checker

bind cgm_mode_ctrl cgm_mode_checker u_chk (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .stopIn(stopIn),
  .loopFilterValue(loopFilterValue), .oscRun(oscRun),
  .loopClosed(loopClosed), .useExtRef(useExtRef), .chipClkEn(chipClkEn),
  .outClkEn(outClkEn), .oscMonEn(oscMonEn),
  .oscStableFlag(oscStableFlag), .modeState(modeState));

// File: bench/cgm_osc_model.sv
// Purpose: oscillator, crystal and loop sample source
// Assumes: crystal runs free at clk/4
// Notes:   errBig puts the count error just past the threshold
`timescale 1ns/1ps
module cgm_osc_model (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // controls
  input  wire logic         oscRun,
  input  wire logic         errBig,
  // clocks and samples
  output logic              oscClkMon,
  output logic              xtalClkMon,
  output logic              sampleValid,
  output logic signed [7:0] countErr
);
  logic [2:0] tick_q;
  // a stopped oscillator stands still, so the static check can trip
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_q      <= 3'h0;
      oscClkMon   <= 1'b0;
      xtalClkMon  <= 1'b0;
      sampleValid <= 1'b0;
      countErr    <= 8'sh00;
    end else begin
      tick_q      <= tick_q + 3'h1;
      oscClkMon   <= oscRun ? ~oscClkMon : oscClkMon;
      xtalClkMon  <= tick_q[0] ? ~xtalClkMon : xtalClkMon;
      sampleValid <= (tick_q == 3'h7);
      countErr    <= errBig ? 8'sh09 : 8'sh08;
    end
  end
endmodule // cgm_osc_model

// File: bench/tb.sv
// Purpose: register-level tests of the mode control
// Assumes: crystal count needs about 16k cycles
// Notes:   loop lock input held low
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb;
  logic clk, resetn, porResetn, regWr, regRd, extOk, loss, errBig;
  logic [2:0]  regAddr;
  logic [7:0]  regWrData, regRdData, trim;
  cgm_pkg::cgm_stop_t stopIn;
  logic sv, oscMon, xtal, oscRun, extRun, loopCl, useExt, chipEn;
  logic outEn, monEn, stbl;
  logic signed [7:0] cErr;
  logic [11:0] filt;
  logic [3:0]  divSh;
  logic [1:0]  modeState;
  int bad_count, num_checks, i;
  cgm_mode_ctrl dut (.clk(clk), .resetn(resetn), .porResetn(porResetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .stopIn(stopIn),
    .sampleValid(sv), .countErr(cErr), .loopLocked(1'b0),
    .extRefOkFlag(extOk), .clockLossFlag(loss), .oscClkMon(oscMon),
    .xtalClkMon(xtal), .loopFilterValue(filt), .trimCode(trim),
    .oscRun(oscRun), .extRefRun(extRun), .loopClosed(loopCl),
    .useExtRef(useExt), .chipClkEn(chipEn), .outClkEn(outEn),
    .outDivShift(divSh), .oscMonEn(monEn), .oscStableFlag(stbl),
    .modeState(modeState));
  cgm_osc_model u_osc (.clk(clk), .resetn(resetn), .oscRun(oscRun),
    .errBig(errBig), .oscClkMon(oscMon), .xtalClkMon(xtal),
    .sampleValid(sv), .countErr(cErr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK("regRdData", e, regRdData)
  endtask
  task automatic wake();
    stopIn <= 3'b001;
    cyc(1);
    stopIn <= 3'b000;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(60000);
    bad_count++;
    summarize();
  end
  initial begin
    resetn = 0; porResetn = 0; regWr = 0; regRd = 0; regAddr = '0;
    regWrData = '0; stopIn = '0; extOk = 0; loss = 0; errBig = 1;
    bad_count = 0; num_checks = 0;
    cyc(10);
    resetn <= 1'b1; porResetn <= 1'b1;
    rd(3'h0, 8'h00);
    rd(3'h3, 8'h02);
    rd(3'h5, 8'h80);
    rd(3'h6, 8'h00);
    cyc(40);
    rd(3'h2, 8'h00);
    errBig <= 1'b0;
    cyc(40);
    rd(3'h2, 8'h01);
    $display("test reset and stable done");
    wr(3'h4, 8'h5A);
    wr(3'h3, 8'hF3);
    wr(3'h3, 8'h07);
    rd(3'h3, 8'h03);
    rd(3'h4, 8'h5A);
    wr(3'h3, 8'h07);
    rd(3'h3, 8'h07);
    wr(3'h0, 8'h01);
    cyc(3);
    rd(3'h1, 8'h40);
    wr(3'h3, 8'h0F);
    rd(3'h3, 8'h07);
    $display("test filter done");
    stopIn <= 3'b100;
    cyc(4);
    `CHK("chipClkEn", 1'b0, chipEn)
    `CHK("stable", 1'b0, stbl)
    wake();
    cyc(3);
    `CHK("modeState", 2'h0, modeState)
    for (i = 0; i < 200 && modeState !== 2'h1; i++) cyc(1);
    `CHK("modeState", 2'h1, modeState)
    `CHK("chipClkEn", 1'b1, chipEn)
    rd(3'h0, 8'h01);
    wr(3'h0, 8'h00);
    cyc(3);
    rd(3'h1, 8'h00);
    stopIn <= 3'b110;
    cyc(5);
    `CHK("chipClkEn", 1'b1, chipEn)
    stopIn <= 3'b000;
    wr(3'h0, 8'h2C);
    stopIn <= 3'b100;
    cyc(5);
    `CHK("chipClkEn", 1'b0, chipEn)
    `CHK("oscRun", 1'b1, oscRun)
    `CHK("extRefRun", 1'b1, extRun)
    `CHK("outDivShift", 4'h3, divSh)
    wake();
    $display("test stop done");
    wr(3'h5, 8'hC3);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    rd(3'h5, 8'hC3);
    `CHK("trimCode", 8'hC3, trim)
    rd(3'h0, 8'h00);
    rd(3'h3, 8'h02);
    extOk <= 1'b1;
    wr(3'h0, 8'h03);
    for (i = 0; i < 200 && modeState !== 2'h3; i++) cyc(1);
    `CHK("modeState", 2'h3, modeState)
    `CHK("outDivShift", 4'h1, divSh)
    wr(3'h0, 8'h42);
    stopIn <= 3'b100;
    cyc(3);
    wake();
    cyc(5);
    `CHK("outClkEn", 1'b0, outEn)
    cyc(1000);
    `CHK("outClkEn", 1'b0, outEn)
    for (i = 0; i < 20000 && outEn !== 1'b1; i++) cyc(1);
    `CHK("outClkEn", 1'b1, outEn)
    `CHK("modeState", 2'h2, modeState)
    loss <= 1'b1; extOk <= 1'b0;
    cyc(5);
    `CHK("modeState", 2'h0, modeState)
    rd(3'h0, 8'h40);
    $display("test crystal done");
    summarize();
  end
endmodule // tb
